// ### rtl/limit_pkg.sv
/*
 * constants for the dual limit checker with digital outputs: register
 * offsets, reset values, widths and timing.
 * assumes a 125 MHz core clock and a 32-bit classic wishbone register bus.
 */
package limit_pkg;
   localparam int unsigned clk_hz = 125000000;
   localparam int mag_w = 32;
   localparam int lim_w = 33;
   localparam logic [32:0] lim_max = 33'h0ffffffff;
   localparam logic [32:0] lim_min = 33'h100000001;
   localparam logic [32:0] pair1_upper_rst = 33'h000000001;
   localparam logic [32:0] pair1_lower_rst = 33'h1ffffffff;
   localparam logic [32:0] pair2_upper_rst = 33'h000000002;
   localparam logic [32:0] pair2_lower_rst = 33'h1fffffffe;
   // pulse time held in milliseconds, 1 .. 99999999
   localparam int unsigned pulse_min_ms = 1;
   localparam int unsigned pulse_max_ms = 99999999;
   localparam int unsigned pulse_rst_ms = 2;
   localparam logic [26:0] pulse_min_ms_w = 27'h0000001;
   localparam logic [26:0] pulse_max_ms_w = 27'h5f5e0ff;
   localparam logic [26:0] pulse_rst_ms_w = 27'h0000002;
   localparam int unsigned ms_cycles = clk_hz / 1000;
   localparam logic [16:0] ms_cycles_w = 17'(ms_cycles);
   localparam int ms_w = 27;
   // register byte offsets
   localparam logic [7:0] off_ctrl = 8'h00;
   localparam logic [7:0] off_status = 8'h04;
   localparam logic [7:0] off_clear = 8'h08;
   localparam logic [7:0] off_pulse = 8'h0c;
   localparam logic [7:0] off_u1_lo = 8'h10;
   localparam logic [7:0] off_u1_hi = 8'h14;
   localparam logic [7:0] off_l1_lo = 8'h18;
   localparam logic [7:0] off_l1_hi = 8'h1c;
   localparam logic [7:0] off_u2_lo = 8'h20;
   localparam logic [7:0] off_u2_hi = 8'h24;
   localparam logic [7:0] off_l2_lo = 8'h28;
   localparam logic [7:0] off_l2_hi = 8'h2c;
   // control bit positions
   localparam int ctl_en1 = 0;
   localparam int ctl_en2 = 1;
   localparam int ctl_auto1 = 2;
   localparam int ctl_auto2 = 3;
   localparam int ctl_sense_low = 4;
   localparam int ctl_out_en = 5;
   localparam int ctl_pulse_en = 6;
   localparam int ctl_latch = 7;
   localparam logic [7:0] ctrl_rst = 8'h0c;
   typedef enum logic {sense_active_high, sense_active_low} output_logic_sense_t;
endpackage

// ### rtl/pulse_timer.sv
/*
 * one output line with optional timed pulse and selectable sense.
 * assumes single core clock; fail and start come from same domain.
 */
`timescale 1ns/1ps
`default_nettype none
module pulse_timer
   import limit_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic out_en,
   input wire logic pulse_en,
   input wire logic sense_low,
   input wire logic [26:0] pulse_ms,
   input wire logic rd_stb,
   input wire logic fail,
   input wire logic level,
   output logic line
);
   logic active_q;
   logic [16:0] sub_q;
   logic [26:0] ms_q;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         active_q <= 1'b0;
         sub_q <= '0;
         ms_q <= '0;
      end else if (!out_en || !pulse_en) begin
         active_q <= 1'b0; // no stale pulse carried over from level mode
      end else if (rd_stb && fail) begin
         active_q <= 1'b1;
         sub_q <= '0;
         ms_q <= '0;
      end else if (rd_stb) begin
         active_q <= 1'b0; // in-limit reading cuts pulse
      end else if (active_q) begin
         if (sub_q == ms_cycles_w - 17'h00001) begin
            sub_q <= '0;
            if (ms_q == pulse_ms - 27'h0000001) begin
               active_q <= 1'b0; // timer expired
            end else begin
               ms_q <= ms_q + 27'h0000001;
            end
         end else begin
            sub_q <= sub_q + 17'h00001;
         end
      end
   end

   logic asserted;
   assign asserted = out_en && (pulse_en ? active_q : level);
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         line <= 1'b0;
      end else begin
         line <= asserted ^ sense_low;
      end
   end
endmodule
`default_nettype wire

// ### rtl/limit_checker.sv
/*
 * dual limit checker with digital outputs and wishbone registers.
 * assumes readings arrive as one-cycle strobes from same-clock logic,
 * idle entry and control-source pass are same-clock pulses.
 */
// Contract
// - each limit is signed, within -4294967295 to +4294967295.
// - reset limits: pair one 1 and -1, pair two 2 and -2.
// - pair one and pair two tests have separate enables.
// - fail flag 0 inside bounds, 1 when reading reaches either bound.
// - flag has no side; side reported on separate event outputs.
// - clear command resets that pair's fail flag.
// - auto clear, default on, clears flag on idle entry.
// - without auto clear, fail persists until clear command.
// - output sense active high or low, default high.
// - output global enable, off after reset, gates all lines.
// - pulse time 0.001 to 99999.999 s, default 0.002 s.
// - pulse mode selectable, off after reset.
// - master line latch selectable, off after reset.
// - pair one enabled: indicators show pair one result.
// - only pair two enabled: indicators show pair two, digit two on a failure, pair two message when in range.
// - panel limit disable turns off both tests.
// - limit sets stored per scan channel, slot 1 or 2.
// - every reading goes to the checker while testing enabled.
// - failing line driven high active-high, low active-low.
// - in-limit reading ends a running pulse at once.
// - master line on any failure; latched holds until control pass; latch acts in level mode only, pulse mode gives a timed pulse.
`timescale 1ns/1ps
`default_nettype none
module limit_checker
   import limit_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic rd_valid,
   input wire logic [32:0] rd_value,
   input wire logic idle_enter,
   input wire logic ctrl_pass,
   input wire logic panel_disable,
   input wire logic chan_load,
   input wire logic [5:0] chan_sel,
   output logic [4:0] dig_out,
   output logic ind_high,
   output logic ind_in,
   output logic ind_low,
   output logic ind_digit_two,
   output logic in_range_pair_two_message,
   output logic [3:0] side_event
);
   logic [32:0] upper_bound_pair_one_q, lower_bound_pair_one_q;
   logic [32:0] upper_bound_pair_two_q, lower_bound_pair_two_q;
   logic [7:0] ctrl_q;
   logic [26:0] pulse_ms_q;
   logic fail1_q, fail2_q;
   logic [3:0] side_q;
   logic master_q;

   // bus strobes; ack given one cycle after request, dropped next cycle
   logic req, wr;
   assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wr = req && wb_we_i;
   logic wr_ctrl, wr_clear, wr_pulse;
   assign wr_ctrl = wr && wb_adr_i == off_ctrl && wb_sel_i[0];
   assign wr_clear = wr && wb_adr_i == off_clear && wb_sel_i[0];
   assign wr_pulse = wr && wb_adr_i == off_pulse;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= req;
      end
   end

   // sign-saturate limit writes into range
   function automatic logic [32:0] clamp(input logic [32:0] v);
      if (!v[32] && v > lim_max) begin
         clamp = lim_max;
      end else if (v[32] && v < lim_min) begin
         clamp = lim_min;
      end else begin
         clamp = v;
      end
   endfunction

   function automatic logic [32:0] merge_lo(input logic [32:0] old, input logic [31:0] d,
                                            input logic [3:0] sel);
      logic [32:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[i*8 +: 8] = d[i*8 +: 8];
         end
      end
      merge_lo = r;
   endfunction

   // per-channel limit store: 64 entries, 4 limits each
   logic [131:0] store_rd;
   logic store_we;
   logic [5:0] store_sel_q;
   logic load_q;
   logic load_qq;
   assign store_we = wr && wb_adr_i == off_clear && wb_sel_i[1];
   limit_store u_store (
      .core_clk(core_clk),
      .we(store_we),
      .waddr(wb_dat_i[13:8]),
      .wdata({upper_bound_pair_one_q, lower_bound_pair_one_q,
              upper_bound_pair_two_q, lower_bound_pair_two_q}),
      .raddr(store_sel_q),
      .rdata(store_rd)
   );
   // entry latched, then read, then loaded: selection need not stand
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         load_q <= 1'b0;
         load_qq <= 1'b0;
         store_sel_q <= '0;
      end else begin
         load_q <= chan_load;
         load_qq <= load_q;
         if (chan_load) begin
            store_sel_q <= chan_sel;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         upper_bound_pair_one_q <= pair1_upper_rst;
         lower_bound_pair_one_q <= pair1_lower_rst;
         upper_bound_pair_two_q <= pair2_upper_rst;
         lower_bound_pair_two_q <= pair2_lower_rst;
      end else if (load_qq) begin
         {upper_bound_pair_one_q, lower_bound_pair_one_q,
          upper_bound_pair_two_q, lower_bound_pair_two_q} <= store_rd;
      end else if (wr) begin
         // both words saturate, so a lone low-word write stays in range
         unique case (wb_adr_i)
            off_u1_lo: upper_bound_pair_one_q <=
               clamp(merge_lo(upper_bound_pair_one_q, wb_dat_i, wb_sel_i));
            off_u1_hi: upper_bound_pair_one_q <=
               clamp({wb_dat_i[0], upper_bound_pair_one_q[31:0]});
            off_l1_lo: lower_bound_pair_one_q <=
               clamp(merge_lo(lower_bound_pair_one_q, wb_dat_i, wb_sel_i));
            off_l1_hi: lower_bound_pair_one_q <=
               clamp({wb_dat_i[0], lower_bound_pair_one_q[31:0]});
            off_u2_lo: upper_bound_pair_two_q <=
               clamp(merge_lo(upper_bound_pair_two_q, wb_dat_i, wb_sel_i));
            off_u2_hi: upper_bound_pair_two_q <=
               clamp({wb_dat_i[0], upper_bound_pair_two_q[31:0]});
            off_l2_lo: lower_bound_pair_two_q <=
               clamp(merge_lo(lower_bound_pair_two_q, wb_dat_i, wb_sel_i));
            off_l2_hi: lower_bound_pair_two_q <=
               clamp({wb_dat_i[0], lower_bound_pair_two_q[31:0]});
            default: ;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_q <= ctrl_rst;
      end else if (panel_disable) begin
         ctrl_q[ctl_en1] <= 1'b0;
         ctrl_q[ctl_en2] <= 1'b0;
      end else if (wr_ctrl) begin
         ctrl_q <= wb_dat_i[7:0];
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pulse_ms_q <= pulse_rst_ms_w;
      end else if (wr_pulse) begin
         if (wb_dat_i[26:0] < pulse_min_ms_w) begin
            pulse_ms_q <= pulse_min_ms_w;
         end else if (wb_dat_i[26:0] > pulse_max_ms_w || wb_dat_i[31:27] != 5'h00) begin
            pulse_ms_q <= pulse_max_ms_w;
         end else begin
            pulse_ms_q <= wb_dat_i[26:0];
         end
      end
   end

   // inclusive signed compares
   logic hi1, lo1, hi2, lo2;
   assign hi1 = $signed(rd_value) >= $signed(upper_bound_pair_one_q);
   assign lo1 = $signed(rd_value) <= $signed(lower_bound_pair_one_q);
   assign hi2 = $signed(rd_value) >= $signed(upper_bound_pair_two_q);
   assign lo2 = $signed(rd_value) <= $signed(lower_bound_pair_two_q);
   logic chk1, chk2;
   assign chk1 = rd_valid && ctrl_q[ctl_en1];
   assign chk2 = rd_valid && ctrl_q[ctl_en2];
   logic f1_now, f2_now;
   assign f1_now = chk1 && (hi1 || lo1);
   assign f2_now = chk2 && (hi2 || lo2);

   // set wins over clear in the same cycle
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         fail1_q <= 1'b0;
      end else if (f1_now) begin
         fail1_q <= 1'b1;
      end else if ((wr_clear && wb_dat_i[0]) || (idle_enter && ctrl_q[ctl_auto1])) begin
         fail1_q <= 1'b0;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         fail2_q <= 1'b0;
      end else if (f2_now) begin
         fail2_q <= 1'b1;
      end else if ((wr_clear && wb_dat_i[1]) || (idle_enter && ctrl_q[ctl_auto2])) begin
         fail2_q <= 1'b0;
      end
   end

   // side of each reading, kept apart from pass/fail
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         side_q <= '0;
      end else if (chk1 || chk2) begin
         side_q <= {chk2 && hi2, chk1 && hi1, chk1 && lo1, chk2 && lo2};
      end
   end
   assign side_event = side_q;

   // master limit
   logic any_fail, all_in;
   assign any_fail = f1_now || f2_now;
   // in unlatched mode only a reading that was tested may release the line
   assign all_in = (chk1 || chk2) && !any_fail;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         master_q <= 1'b0;
      end else if (any_fail) begin
         master_q <= 1'b1;
      end else if (ctrl_q[ctl_latch] ? ctrl_pass : all_in) begin
         master_q <= 1'b0;
      end
   end

   // outputs: 1 lo1, 2 hi1, 3 lo2, 4 hi2, 5 master
   logic [4:0] line_fail, line_lvl;
   assign line_fail = {any_fail, chk2 && hi2, chk2 && lo2, chk1 && hi1, chk1 && lo1};
   assign line_lvl = {master_q, side_q[3], side_q[0], side_q[2], side_q[1]};
   output_logic_sense_t line_sense;
   assign line_sense = ctrl_q[ctl_sense_low] ? sense_active_low : sense_active_high;
   genvar g;
   generate
      for (g = 0; g < 5; g++) begin : g_line
         pulse_timer u_line (
            .core_clk(core_clk),
            .rst_n(rst_n),
            .out_en(ctrl_q[ctl_out_en]),
            .pulse_en(ctrl_q[ctl_pulse_en]),
            .sense_low(line_sense == sense_active_low),
            .pulse_ms(pulse_ms_q),
            .rd_stb(rd_valid),
            .fail(line_fail[g]),
            .level(line_lvl[g]),
            .line(dig_out[g])
         );
      end
   endgenerate

   // front panel indicators
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         ind_high <= 1'b0;
         ind_in <= 1'b0;
         ind_low <= 1'b0;
         ind_digit_two <= 1'b0;
         in_range_pair_two_message <= 1'b0;
      end else if (chk1) begin
         ind_high <= hi1;
         ind_low <= lo1 && !hi1;
         ind_in <= !(hi1 || lo1);
         ind_digit_two <= 1'b0;
         in_range_pair_two_message <= 1'b0;
      end else if (chk2) begin
         ind_high <= hi2;
         ind_low <= lo2 && !hi2;
         ind_in <= 1'b0;
         ind_digit_two <= hi2 || lo2;
         in_range_pair_two_message <= !(hi2 || lo2);
      end
   end

   logic [31:0] status_word;
   assign status_word = {23'h000000, master_q, side_q, 2'h0, fail2_q, fail1_q};

   // read mux, registered
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         wb_dat_o <= '0;
      end else if (req && !wb_we_i) begin
         unique case (wb_adr_i)
            off_ctrl: wb_dat_o <= {24'h000000, ctrl_q};
            off_status: wb_dat_o <= status_word;
            off_pulse: wb_dat_o <= {5'h00, pulse_ms_q};
            off_u1_lo: wb_dat_o <= upper_bound_pair_one_q[31:0];
            off_u1_hi: wb_dat_o <= {31'h00000000, upper_bound_pair_one_q[32]};
            off_l1_lo: wb_dat_o <= lower_bound_pair_one_q[31:0];
            off_l1_hi: wb_dat_o <= {31'h00000000, lower_bound_pair_one_q[32]};
            off_u2_lo: wb_dat_o <= upper_bound_pair_two_q[31:0];
            off_u2_hi: wb_dat_o <= {31'h00000000, upper_bound_pair_two_q[32]};
            off_l2_lo: wb_dat_o <= lower_bound_pair_two_q[31:0];
            off_l2_hi: wb_dat_o <= {31'h00000000, lower_bound_pair_two_q[32]};
            default: wb_dat_o <= '0;
         endcase
      end
   end

endmodule
`default_nettype wire

// ### rtl/limit_store.sv
/*
 * per-channel limit memory, 64 entries of four 33-bit limits.
 * assumes single clock; read data registered.
 */
`timescale 1ns/1ps
`default_nettype none
module limit_store (
   input wire logic core_clk,
   input wire logic we,
   input wire logic [5:0] waddr,
   input wire logic [131:0] wdata,
   input wire logic [5:0] raddr,
   output logic [131:0] rdata
);
   logic [131:0] mem [0:63];
   always_ff @(posedge core_clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
   end
endmodule
`default_nettype wire

// ### testbench/limit_checker_asserts.sv
/* checker for the limit checker top: output gating, master line, indicators, bus answer.
   assumes one core clock; mirrors the control register from bus writes. */
`timescale 1ns/1ps
`default_nettype none
module limit_checker_asserts
   import limit_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic wb_ack_o,
   input wire logic rd_valid,
   input wire logic panel_disable,
   input wire logic [4:0] dig_out,
   input wire logic ind_high,
   input wire logic ind_in,
   input wire logic ind_low,
   input wire logic ind_digit_two,
   input wire logic in_range_pair_two_message
);
   logic [7:0] ctl_q;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   // control copy, panel disable drops both test enables
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) ctl_q <= ctrl_rst;
      else if (panel_disable) ctl_q <= ctl_q & 8'hfc;
      else if (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_adr_i == off_ctrl
               && wb_sel_i[0]) ctl_q <= wb_dat_i[7:0];
   end
   property p_ack_answer;
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
   endproperty
   property p_ack_single;
      wb_ack_o |=> !wb_ack_o;
   endproperty
   property p_outputs_off;
      (!ctl_q[ctl_out_en] && !ctl_q[ctl_sense_low]) [*3] |-> dig_out == 5'h00;
   endproperty
   property p_in_excl;
      ind_in |-> !ind_high && !ind_low;
   endproperty
   property p_two_msg;
      in_range_pair_two_message |-> !ind_high && !ind_low && !ind_digit_two;
   endproperty
   property p_pair_one_shown;
      rd_valid && ctl_q[ctl_en1] && !panel_disable |=>
         !ind_digit_two && !in_range_pair_two_message;
   endproperty
   property p_pair_two_shown;
      rd_valid && !ctl_q[ctl_en1] && ctl_q[ctl_en2] && !panel_disable |=>
         ind_digit_two || in_range_pair_two_message;
   endproperty
   property p_master_any;
      (ctl_q[ctl_out_en] && !ctl_q[ctl_pulse_en] && !ctl_q[ctl_sense_low]
         && !ctl_q[ctl_latch]) [*3] ##0 (|dig_out[3:0]) |-> dig_out[4];
   endproperty
   a_ack_answer: assert property (p_ack_answer) else $error("no ack after request");
   a_ack_single: assert property (p_ack_single) else $error("ack longer than one cycle");
   a_outputs_off: assert property (p_outputs_off) else $error("lines move while off");
   a_in_excl: assert property (p_in_excl) else $error("in shown with high or low");
   a_two_msg: assert property (p_two_msg) else $error("pair two message clash");
   a_pair_one_shown: assert property (p_pair_one_shown) else $error("pair two shown");
   a_pair_two_shown: assert property (p_pair_two_shown) else $error("pair two hidden");
   a_master_any: assert property (p_master_any) else $error("master line not set");
   c_master: cover property (dig_out[4]);
   c_digit_two: cover property (ind_digit_two);
   c_in_two: cover property (in_range_pair_two_message);
endmodule
bind limit_checker limit_checker_asserts limit_checker_asserts_inst (.core_clk, .rst_n,
   .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o, .rd_valid,
   .panel_disable, .dig_out, .ind_high, .ind_in, .ind_low, .ind_digit_two,
   .in_range_pair_two_message);
`default_nettype wire

// ### testbench/component_handler.sv
/* handler model: sorts a part into a bin from the limit lines.
   assumes lines sampled on the core clock with the programmed sense. */
`timescale 1ns/1ps
`default_nettype none
module component_handler (
   input wire logic core_clk,
   input wire logic sense_low,
   input wire logic [4:0] lines,
   output logic [1:0] bin
);
   logic [4:0] act;
   assign act = sense_low ? ~lines : lines;
   always_ff @(posedge core_clk) begin
      if (act[3] || act[2]) bin <= 2'h3;
      else if (act[1] || act[0]) bin <= 2'h2;
      else bin <= 2'h1;
   end
endmodule
`default_nettype wire

// ### testbench/testbench.sv
/* bench for the limit checker: bus tasks, readings, line and indicator checks.
   assumes a one-cycle bus answer and registered outputs. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin fails++; \
   $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module testbench;
   import limit_pkg::*;
   logic core_clk, rst_n, cyc, stb, we, ack, rd_valid, idle_enter, ctrl_pass, panel_disable;
   logic ind_high, ind_in, ind_low, ind_two, in_two;
   logic [7:0] adr;
   logic [3:0] sel, side;
   logic [31:0] wdat, rdat, d;
   logic [32:0] rd_value;
   logic [4:0] dig_out;
   logic [1:0] bin;
   logic chan_load;
   logic [5:0] chan_sel;
   int fails, samples_checked;
   limit_checker limit_checker_inst (.core_clk, .rst_n, .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .rd_valid, .rd_value, .idle_enter, .ctrl_pass, .panel_disable,
      .chan_load, .chan_sel, .dig_out, .ind_high, .ind_in, .ind_low,
      .ind_digit_two(ind_two), .in_range_pair_two_message(in_two), .side_event(side));
   component_handler component_handler_inst (.core_clk, .sense_low(1'b0), .lines(dig_out),
      .bin);
   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= wd;
      sel <= 4'hf;
      do begin
         @(posedge core_clk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      d = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (n >= 20) fails++;
      @(posedge core_clk);
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h0);
      `CHK("register", e, d)
   endtask
   task automatic rdg(input logic [32:0] v);
      rd_valid <= 1'b1;
      rd_value <= v;
      @(posedge core_clk);
      rd_valid <= 1'b0;
      repeat (3) @(posedge core_clk);
   endtask
   // one-cycle pulse on whichever strobe the caller raised
   task automatic tick();
      @(posedge core_clk);
      {idle_enter, ctrl_pass, panel_disable, chan_load} <= 4'h0;
      repeat (2) @(posedge core_clk);
   endtask
   initial begin
      repeat (5000) @(posedge core_clk);
      fails++;
      wrap_up();
   end
   initial begin
      {rst_n, cyc, stb, we, rd_valid, idle_enter, ctrl_pass, panel_disable} = 8'h00;
      adr = 8'h00;
      sel = 4'h0;
      wdat = 32'h0;
      rd_value = 33'h0;
      chan_load = 1'b0;
      chan_sel = 6'h00;
      repeat (10) @(posedge core_clk);
      rst_n <= 1'b1;
      @(posedge core_clk);
      rchk(off_ctrl, 32'h0000000c);
      rchk(off_pulse, 32'h00000002);
      rchk(off_u1_lo, 32'h00000001);
      rchk(off_u1_hi, 32'h00000000);
      rchk(off_l1_lo, 32'hffffffff);
      rchk(off_l1_hi, 32'h00000001);
      rchk(off_u2_lo, 32'h00000002);
      rchk(off_l2_lo, 32'hfffffffe);
      rchk(8'h40, 32'h00000000);
      xfer(1'b1, off_l2_lo, 32'h00000000);
      xfer(1'b1, off_l2_hi, 32'h00000001);
      rchk(off_l2_lo, 32'h00000001);
      xfer(1'b1, off_ctrl, 32'h0000002d);
      rdg(33'h000000001);
      rchk(off_status, 32'h00000141);
      `CHK("lines", 5'h12, dig_out)
      `CHK("bin", 2'h2, bin)
      `CHK("side", 4'h4, side)
      rdg(33'h000000000);
      rchk(off_status, 32'h00000001);
      `CHK("lines", 5'h00, dig_out)
      idle_enter <= 1'b1;
      tick();
      rchk(off_status, 32'h00000000);
      xfer(1'b1, off_ctrl, 32'h00000029);
      rdg(33'h1ffffffff);
      idle_enter <= 1'b1;
      tick();
      rchk(off_status, 32'h00000121);
      xfer(1'b1, off_clear, 32'h00000001);
      rchk(off_status, 32'h00000120);
      xfer(1'b1, off_ctrl, 32'h00000039);
      rdg(33'h1ffffffff);
      `CHK("lines", 5'h0e, dig_out)
      xfer(1'b1, off_ctrl, 32'h00000069);
      rdg(33'h000000001);
      `CHK("pulse line", 1'b1, dig_out[1])
      rdg(33'h000000000);
      `CHK("pulse line", 1'b0, dig_out[1])
      xfer(1'b1, off_ctrl, 32'h000000a1);
      rdg(33'h000000001);
      rdg(33'h000000000);
      `CHK("lines", 5'h10, dig_out)
      ctrl_pass <= 1'b1;
      tick();
      `CHK("lines", 5'h00, dig_out)
      xfer(1'b1, off_ctrl, 32'h00000022);
      rdg(33'h000000003);
      `CHK("indicators", 4'ha, {ind_high, ind_low, ind_two, in_two})
      `CHK("lines", 5'h18, dig_out)
      `CHK("bin", 2'h3, bin)
      rdg(33'h000000000);
      `CHK("indicators", 4'h1, {ind_high, ind_low, ind_two, in_two})
      xfer(1'b1, off_ctrl, 32'h00000003);
      rdg(33'h000000000);
      `CHK("indicators", 2'h2, {ind_in, ind_two})
      xfer(1'b1, off_clear, 32'h00000300);
      xfer(1'b1, off_u1_lo, 32'h00000005);
      rchk(off_u1_lo, 32'h00000005);
      chan_sel <= 6'h03;
      chan_load <= 1'b1;
      tick();
      rchk(off_u1_lo, 32'h00000001);
      panel_disable <= 1'b1;
      tick();
      rchk(off_ctrl, 32'h00000000);
      wrap_up();
   end
endmodule
`default_nettype wire
